/* rtl/apam_params.svh */
`ifndef APAM_PARAMS_SVH
`define APAM_PARAMS_SVH

// Register indices; byte address is four times the index
`define APAM_IDX_CMD 8'h50
`define APAM_IDX_STATUS 8'h51
`define APAM_IDX_VMASK 8'h52
`define APAM_IDX_HM_AFTER 8'h53
`define APAM_IDX_HM_BEFORE 8'h54
`define APAM_IDX_OPTIONS 8'h55
`define APAM_IDX_THRESH 8'h56
`define APAM_IDX_RESULT3 8'h57
`define APAM_IDX_RESULT2 8'h58
`define APAM_IDX_RESULT1 8'h59
`define APAM_IDX_RESULT0 8'h5A

// Reset values and the vmask write mask
`define APAM_RST_VMASK 8'h01
`define APAM_RST_HM_AFTER 8'h01
`define APAM_RST_HM_BEFORE 8'h01
`define APAM_RST_OPTIONS 8'h20
`define APAM_RST_THRESH 8'h0A
`define APAM_VMASK_WMASK 8'h77

// Field positions in the options and status registers
`define APAM_OPT_BLUE_OFF 0
`define APAM_OPT_GREEN_OFF 1
`define APAM_OPT_RED_OFF 2
`define APAM_OPT_TARGET 3
`define APAM_OPT_LENGTH 4
`define APAM_OPT_ON_VSYNC 5
`define APAM_OPT_SOFT_RST 6
`define APAM_STATUS_BUSY 7

// Command codes
`define APAM_CMD_SET_PHASE 3'h3
`define APAM_CMD_APPLY_DATA_ENABLE_COMMAND 3'h4

// Search lengths in vertical sync intervals
`define APAM_STEPS_FAST 7'h1C
`define APAM_STEPS_SLOW 7'h40
// Fast search spreads 28 steps over 64 phases: phase = step*73/32
`define APAM_FAST_MUL 7'h49

`endif

/* rtl/apam_pkg.sv */
package apam_pkg;

  typedef enum logic [1:0] {
    s_idle,
    s_arm,
    s_meas,
    s_apply
  } apam_state_t;

  typedef logic [5:0] apam_phase_t;

endpackage : apam_pkg

/* rtl/apam_chan_edge.sv */
`timescale 1ns/10ps
`default_nettype none
`include "apam_params.svh"

module apam_chan_edge (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic srst,
  // Pixel stream and settings
  input wire logic [7:0] pix,
  input wire logic chan_off,
  input wire logic [7:0] thresh,
  // Transition flag
  output logic edge_hit
);

  logic [7:0] prev_ff;
  logic [7:0] nxt_prev;
  logic hit_ff;
  logic nxt_hit;
  logic [8:0] diff;
  logic [9:0] thr_full;

  // Compare this pixel against the last one
  always_comb begin
    diff = (pix > prev_ff) ? {1'b0, pix - prev_ff} : {1'b0, prev_ff - pix};
    thr_full = {thresh, 2'b00};
    nxt_prev = pix;
    nxt_hit = !chan_off && ({1'b0, diff} > thr_full);
  end

  // Soft reset clears the history so no stale edge is counted
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_ff <= 8'h00;
      hit_ff <= 1'b0;
    end else if (srst) begin
      prev_ff <= 8'h00;
      hit_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      hit_ff <= nxt_hit;
    end
  end

  assign edge_hit = hit_ff;

  property p_thr_hit;
    @(posedge clk_sys) disable iff (rst)
    hit_ff |-> $past(!chan_off && !srst) &&
      ({2'b00, $past(diff)} > {$past(thresh), 2'b00});
  endproperty
  a_thr_hit: assert property (p_thr_hit)
    else $error("transition flag set below threshold");

endmodule : apam_chan_edge
`default_nettype wire

/* rtl/apam_mask_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "apam_params.svh"

module apam_mask_gen (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic srst,
  // Sync events
  input wire logic hs_rise,
  input wire logic vs_rise,
  // Mask settings
  input wire logic [2:0] code_before,
  input wire logic [2:0] code_after,
  input wire logic [7:0] h_after,
  input wire logic [7:0] h_before,
  // Pixel takes part
  output logic pix_ok
);

  logic [15:0] pix_cnt_ff, nxt_pix_cnt;
  logic [15:0] line_len_ff, nxt_line_len;
  logic [11:0] line_cnt_ff, nxt_line_cnt;
  logic [11:0] frame_len_ff, nxt_frame_len;
  logic ok_ff, nxt_ok;
  logic [5:0] lines_before, lines_after;

  // Line counts excluded around the vertical sync
  always_comb begin
    unique case (code_before)
      3'h0: lines_before = 6'h00;
      3'h1: lines_before = 6'h01;
      3'h2: lines_before = 6'h02;
      3'h3: lines_before = 6'h04;
      3'h4: lines_before = 6'h06;
      3'h5: lines_before = 6'h08;
      3'h6: lines_before = 6'h0A;
      3'h7: lines_before = 6'h0C;
    endcase
    unique case (code_after)
      3'h0: lines_after = 6'h05;
      3'h1: lines_after = 6'h12;
      3'h2: lines_after = 6'h13;
      3'h3: lines_after = 6'h14;
      3'h4: lines_after = 6'h16;
      3'h5: lines_after = 6'h19;
      3'h6: lines_after = 6'h29;
      3'h7: lines_after = 6'h2C;
    endcase
  end

  // Positions count from the sync edges; the trailing masks use the
  // length of the previous line and frame, so the first ones mask everything
  always_comb begin
    nxt_pix_cnt = hs_rise ? 16'h0000 :
      ((&pix_cnt_ff) ? pix_cnt_ff : pix_cnt_ff + 16'h0001);
    nxt_line_len = hs_rise ? pix_cnt_ff : line_len_ff;
    nxt_line_cnt = vs_rise ? 12'h000 :
      ((hs_rise && !(&line_cnt_ff)) ? line_cnt_ff + 12'h001 : line_cnt_ff);
    nxt_frame_len = vs_rise ? line_cnt_ff : frame_len_ff;
    nxt_ok = !hs_rise &&
      (line_cnt_ff >= {6'h00, lines_after}) &&
      ({1'b0, line_cnt_ff} + {7'h00, lines_before} <
        {1'b0, frame_len_ff}) &&
      (pix_cnt_ff >= {7'h00, h_after, 1'b0}) &&
      ({1'b0, pix_cnt_ff} + {8'h00, h_before, 1'b0} <
        {1'b0, line_len_ff});
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pix_cnt_ff <= 16'h0000;
      line_len_ff <= 16'h0000;
      line_cnt_ff <= 12'h000;
      frame_len_ff <= 12'h000;
      ok_ff <= 1'b0;
    end else if (srst) begin
      pix_cnt_ff <= 16'h0000;
      line_len_ff <= 16'h0000;
      line_cnt_ff <= 12'h000;
      frame_len_ff <= 12'h000;
      ok_ff <= 1'b0;
    end else begin
      pix_cnt_ff <= nxt_pix_cnt;
      line_len_ff <= nxt_line_len;
      line_cnt_ff <= nxt_line_cnt;
      frame_len_ff <= nxt_frame_len;
      ok_ff <= nxt_ok;
    end
  end

  assign pix_ok = ok_ff;

  property p_hmask_after;
    @(posedge clk_sys) disable iff (rst)
    (pix_cnt_ff < {7'h00, h_after, 1'b0}) |=> !ok_ff;
  endproperty
  a_hmask_after: assert property (p_hmask_after)
    else $error("pixel after hsync edge not masked");

  property p_vmask_after;
    @(posedge clk_sys) disable iff (rst)
    (line_cnt_ff < {6'h00, lines_after}) |=> !ok_ff;
  endproperty
  a_vmask_after: assert property (p_vmask_after)
    else $error("line after vsync edge not masked");

endmodule : apam_mask_gen
`default_nettype wire

/* rtl/apam_top.sv */
// Our own choice: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "apam_params.svh"

module apam_top
  import apam_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Avalon-MM slave, byte addressed
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Video input pins
  input wire logic [7:0] pix_red,
  input wire logic [7:0] pix_green,
  input wire logic [7:0] pix_blue,
  input wire logic hsync_output,
  input wire logic vsync_in,
  // Phase and window control
  output logic [5:0] sample_phase,
  output logic de_window_load,
  output logic phase_operation_active
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  logic [23:0] pix_s1_ff, pix_s2_ff;
  logic [1:0] sync_s1_ff, sync_s2_ff, sync_s3_ff;

  // Only the second stage feeds logic; the third gives edge history
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pix_s1_ff <= 24'h000000;
      pix_s2_ff <= 24'h000000;
      sync_s1_ff <= 2'h0;
      sync_s2_ff <= 2'h0;
      sync_s3_ff <= 2'h0;
    end else begin
      pix_s1_ff <= {pix_red, pix_green, pix_blue};
      pix_s2_ff <= pix_s1_ff;
      sync_s1_ff <= {vsync_in, hsync_output};
      sync_s2_ff <= sync_s1_ff;
      sync_s3_ff <= sync_s2_ff;
    end
  end

  logic hs_rise, vs_rise;
  assign hs_rise = sync_s2_ff[0] && !sync_s3_ff[0];
  assign vs_rise = sync_s2_ff[1] && !sync_s3_ff[1];

  ////////////////////////////////////////////////////////////////////////
  // Register bus

  logic [7:0] vmask_ff, hm_after_ff, hm_before_ff, opt_ff, thr_ff;
  logic [7:0] nxt_vmask, nxt_hm_after, nxt_hm_before, nxt_opt, nxt_thr;
  logic wait_ff, nxt_wait;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [7:0] idx;
  logic wr_take, cmd_phase, cmd_de;
  logic [31:0] ext_ff;
  apam_state_t state_ff;

  assign idx = avs_address[9:2];
  // A write lands only at the edge where waitrequest is seen low
  assign wr_take = avs_write && !wait_ff && avs_byteenable[0];
  assign cmd_phase = wr_take && (idx == `APAM_IDX_CMD) &&
    (avs_writedata[2:0] == `APAM_CMD_SET_PHASE);
  assign cmd_de = wr_take && (idx == `APAM_IDX_CMD) &&
    (avs_writedata[2:0] == `APAM_CMD_APPLY_DATA_ENABLE_COMMAND);

  // Answer one cycle after a request; unmapped reads return zero
  always_comb begin
    nxt_wait = !((avs_read || avs_write) && wait_ff);
    nxt_rdata = rdata_ff;
    if (avs_read && wait_ff) begin
      unique case (idx)
        `APAM_IDX_STATUS: nxt_rdata = {24'h000000,
          state_ff != s_idle, 7'h00};
        `APAM_IDX_VMASK: nxt_rdata = {24'h000000, vmask_ff};
        `APAM_IDX_HM_AFTER: nxt_rdata = {24'h000000, hm_after_ff};
        `APAM_IDX_HM_BEFORE: nxt_rdata = {24'h000000, hm_before_ff};
        `APAM_IDX_OPTIONS: nxt_rdata = {24'h000000, opt_ff};
        `APAM_IDX_THRESH: nxt_rdata = {24'h000000, thr_ff};
        // Result bytes expose the extreme count; not to be relied on
        `APAM_IDX_RESULT3: nxt_rdata = {24'h000000, ext_ff[31:24]};
        `APAM_IDX_RESULT2: nxt_rdata = {24'h000000, ext_ff[23:16]};
        `APAM_IDX_RESULT1: nxt_rdata = {24'h000000, ext_ff[15:8]};
        `APAM_IDX_RESULT0: nxt_rdata = {24'h000000, ext_ff[7:0]};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  // Settings registers; bit 7 of options is kept as written
  always_comb begin
    nxt_vmask = vmask_ff;
    nxt_hm_after = hm_after_ff;
    nxt_hm_before = hm_before_ff;
    nxt_opt = opt_ff;
    nxt_thr = thr_ff;
    if (wr_take) begin
      unique case (idx)
        `APAM_IDX_VMASK:
          nxt_vmask = avs_writedata[7:0] & `APAM_VMASK_WMASK;
        `APAM_IDX_HM_AFTER: nxt_hm_after = avs_writedata[7:0];
        `APAM_IDX_HM_BEFORE: nxt_hm_before = avs_writedata[7:0];
        `APAM_IDX_OPTIONS: nxt_opt = avs_writedata[7:0];
        `APAM_IDX_THRESH: nxt_thr = avs_writedata[7:0];
        default: nxt_opt = opt_ff;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= 32'h00000000;
      vmask_ff <= `APAM_RST_VMASK;
      hm_after_ff <= `APAM_RST_HM_AFTER;
      hm_before_ff <= `APAM_RST_HM_BEFORE;
      opt_ff <= `APAM_RST_OPTIONS;
      thr_ff <= `APAM_RST_THRESH;
    end else begin
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      vmask_ff <= nxt_vmask;
      hm_after_ff <= nxt_hm_after;
      hm_before_ff <= nxt_hm_before;
      opt_ff <= nxt_opt;
      thr_ff <= nxt_thr;
    end
  end

  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Measurement datapath

  logic srst;
  logic [2:0] hits;
  logic pix_ok;
  assign srst = opt_ff[`APAM_OPT_SOFT_RST];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      apam_chan_edge u_edge (
        .clk_sys(clk_sys),
        .rst(rst),
        .srst(srst),
        .pix(pix_s2_ff[gi*8 +: 8]),
        .chan_off(opt_ff[gi]),
        .thresh(thr_ff),
        .edge_hit(hits[gi])
      );
    end
  endgenerate

  apam_mask_gen u_mask (
    .clk_sys(clk_sys),
    .rst(rst),
    .srst(srst),
    .hs_rise(hs_rise),
    .vs_rise(vs_rise),
    .code_before(vmask_ff[2:0]),
    .code_after(vmask_ff[6:4]),
    .h_after(hm_after_ff),
    .h_before(hm_before_ff),
    .pix_ok(pix_ok)
  );

  ////////////////////////////////////////////////////////////////////////
  // Phase search

  apam_state_t nxt_state;
  logic [6:0] step_ff, nxt_step, last_step;
  logic [31:0] acc_ff, nxt_acc, nxt_ext;
  apam_phase_t cand_ff, nxt_cand, ext_ph_ff, nxt_ext_ph;
  apam_phase_t phase_ff, nxt_phase;
  logic have_ff, nxt_have, slow_ff, nxt_slow, de_ff, nxt_de, better;
  logic [13:0] fast_prod;
  logic [1:0] hit_sum;

  assign hit_sum = {1'b0, hits[0]} + {1'b0, hits[1]} + {1'b0, hits[2]};
  assign last_step = slow_ff ? `APAM_STEPS_SLOW - 7'h01 :
    `APAM_STEPS_FAST - 7'h01;
  assign fast_prod = nxt_step * `APAM_FAST_MUL;
  // Best phase has most sharp transitions, worst has fewest
  assign better = !have_ff || (opt_ff[`APAM_OPT_TARGET] ?
    (acc_ff < ext_ff) : (acc_ff > ext_ff));

  // Candidate phase drives sampling while searching; one per frame
  always_comb begin
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_acc = acc_ff;
    nxt_ext = ext_ff;
    nxt_ext_ph = ext_ph_ff;
    nxt_have = have_ff;
    nxt_slow = slow_ff;
    nxt_phase = phase_ff;
    nxt_de = cmd_de;
    unique case (state_ff)
      s_idle: begin
        if (cmd_phase) begin
          nxt_state = s_arm;
          nxt_step = 7'h00;
          nxt_have = 1'b0;
          nxt_slow = opt_ff[`APAM_OPT_LENGTH];
        end
      end
      s_arm: begin
        if (vs_rise) begin
          nxt_state = s_meas;
          nxt_acc = 32'h00000000;
        end
      end
      s_meas: begin
        if (vs_rise) begin
          nxt_acc = 32'h00000000;
          nxt_step = step_ff + 7'h01;
          if (better) begin
            nxt_ext = acc_ff;
            nxt_ext_ph = cand_ff;
            nxt_have = 1'b1;
          end
          if (step_ff == last_step) begin
            nxt_state = s_apply;
          end
        end else if (pix_ok && !(&acc_ff)) begin
          nxt_acc = acc_ff + {30'h00000000, hit_sum};
        end
      end
      s_apply: begin
        if (!opt_ff[`APAM_OPT_ON_VSYNC] || vs_rise) begin
          nxt_phase = ext_ph_ff;
          nxt_state = s_idle;
        end
      end
    endcase
    nxt_cand = nxt_slow ? nxt_step[5:0] : fast_prod[10:5];
    if (nxt_state == s_meas || nxt_state == s_arm) begin
      nxt_phase = nxt_cand;
    end
  end

  // Soft reset parks the search; the applied phase is kept
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= s_idle;
      step_ff <= 7'h00;
      acc_ff <= 32'h00000000;
      ext_ff <= 32'h00000000;
      ext_ph_ff <= 6'h00;
      cand_ff <= 6'h00;
      have_ff <= 1'b0;
      slow_ff <= 1'b0;
      phase_ff <= 6'h00;
      de_ff <= 1'b0;
    end else if (srst) begin
      state_ff <= s_idle;
      step_ff <= 7'h00;
      acc_ff <= 32'h00000000;
      have_ff <= 1'b0;
      de_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      acc_ff <= nxt_acc;
      ext_ff <= nxt_ext;
      ext_ph_ff <= nxt_ext_ph;
      cand_ff <= nxt_cand;
      have_ff <= nxt_have;
      slow_ff <= nxt_slow;
      phase_ff <= nxt_phase;
      de_ff <= nxt_de;
    end
  end

  logic busy_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != s_idle) && !srst;
    end
  end

  assign sample_phase = phase_ff;
  assign de_window_load = de_ff;
  assign phase_operation_active = busy_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_cmd_start;
    @(posedge clk_sys) disable iff (rst)
    (cmd_phase && state_ff == s_idle && !srst) |=> busy_ff && state_ff == s_arm;
  endproperty
  a_cmd_start: assert property (p_cmd_start)
    else $error("phase command did not start search");

  property p_de_pulse;
    @(posedge clk_sys) disable iff (rst)
    (cmd_de && !srst) |=> de_ff ##1 !de_ff || $past(cmd_de);
  endproperty
  a_de_pulse: assert property (p_de_pulse)
    else $error("window command pulse wrong");

  property p_soft_reset;
    @(posedge clk_sys) disable iff (rst)
    srst |=> state_ff == s_idle && !busy_ff;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset did not park search");

  property p_busy_match;
    @(posedge clk_sys) disable iff (rst)
    busy_ff == (state_ff != s_idle);
  endproperty
  a_busy_match: assert property (p_busy_match)
    else $error("busy status disagrees with search state");

  property p_apply_now;
    @(posedge clk_sys) disable iff (rst)
    (state_ff == s_apply && !opt_ff[`APAM_OPT_ON_VSYNC] && !srst) |=>
      phase_ff == $past(ext_ph_ff) && state_ff == s_idle;
  endproperty
  a_apply_now: assert property (p_apply_now)
    else $error("immediate phase update missed");

  property p_fast_len;
    @(posedge clk_sys) disable iff (rst)
    (state_ff == s_meas && !slow_ff) |-> step_ff < `APAM_STEPS_FAST;
  endproperty
  a_fast_len: assert property (p_fast_len)
    else $error("fast search ran too long");

  property p_blue_off;
    @(posedge clk_sys) disable iff (rst)
    opt_ff[`APAM_OPT_BLUE_OFF] [*2] |-> !hits[0];
  endproperty
  a_blue_off: assert property (p_blue_off)
    else $error("disabled blue channel counted");

  property p_wait_answer;
    @(posedge clk_sys) disable iff (rst)
    ((avs_read || avs_write) && wait_ff) |=> !wait_ff ##1 wait_ff;
  endproperty
  a_wait_answer: assert property (p_wait_answer)
    else $error("bus answer not one cycle");

endmodule : apam_top
`default_nettype wire

/* dv/test_apam_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "apam_params.svh"

module test_apam_top;
  // Clock, reset and bus master signals
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [9:0] avs_address = 10'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // Video stimulus and design outputs
  logic [7:0] pix_red = 8'h00;
  logic [7:0] pix_green = 8'h00;
  logic [7:0] pix_blue = 8'h00;
  logic hsync_output = 1'b0;
  logic vsync_in = 1'b0;
  logic [5:0] sample_phase;
  logic de_window_load;
  logic phase_operation_active;
  // Bench state
  int fails = 0;
  int total_checks = 0;
  int de_cnt = 0;
  logic [31:0] rd;
  logic [4:0] hcnt = 5'h00;
  logic [3:0] lcnt = 4'h0;
  logic tog = 1'b0;
  logic [5:0] tgt = 6'h00;
  logic [7:0] a_hit = 8'h00;
  logic [7:0] a_miss = 8'h00;
  logic [2:0] chn = 3'h7;
  wire logic [7:0] amp;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and design
  always #12.5 clk_sys = ~clk_sys;

  apam_top apam_top_i (
    .clk_sys(clk_sys),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .pix_red(pix_red),
    .pix_green(pix_green),
    .pix_blue(pix_blue),
    .hsync_output(hsync_output),
    .vsync_in(vsync_in),
    .sample_phase(sample_phase),
    .de_window_load(de_window_load),
    .phase_operation_active(phase_operation_active)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Video source: 20-pixel lines, 12-line frames, toggling pixels
  // Swing depends on the phase, so one phase stands out as sharp or blurred
  assign amp = (sample_phase === tgt) ? a_hit : a_miss;

  always @(posedge clk_sys) begin
    hcnt <= (hcnt == 5'h13) ? 5'h00 : hcnt + 5'h01;
    if (hcnt == 5'h13) begin
      lcnt <= (lcnt == 4'hB) ? 4'h0 : lcnt + 4'h1;
    end
    hsync_output <= (hcnt < 5'h02);
    vsync_in <= (lcnt == 4'h0);
    tog <= ~tog;
    pix_red <= (chn[2] && tog) ? amp : 8'h00;
    pix_green <= (chn[1] && tog) ? amp : 8'h00;
    pix_blue <= (chn[0] && tog) ? amp : 8'h00;
  end

  // Count window pulses so a missing or doubled one shows up
  always @(posedge clk_sys) begin
    if (de_window_load === 1'b1) begin
      de_cnt <= de_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking and bus tasks
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One Avalon cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) begin
      fails++;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp,
                        input string what);
    bus(1'b0, idx, 8'h00);
    check(what, rd, exp);
  endtask : rd_chk

  // Start a search and compare the phase it settles on
  task automatic search(input logic [7:0] opt, input logic [5:0] t,
                        input logic [7:0] hit, input logic [7:0] miss,
                        input logic [2:0] ch, input logic [5:0] exp);
    int n;
    tgt <= t;
    a_hit <= hit;
    a_miss <= miss;
    chn <= ch;
    bus(1'b1, `APAM_IDX_OPTIONS, opt);
    bus(1'b1, `APAM_IDX_CMD, 8'h03);
    check("active", {31'h0, phase_operation_active}, 32'h1);
    rd_chk(`APAM_IDX_STATUS, 32'h80, "busy");
    n = 0;
    while (phase_operation_active !== 1'b0 && n < 40000) begin
      @(posedge clk_sys);
      n++;
    end
    if (opt[5] == 1'b0) begin
      check("phase now", {26'h0, sample_phase}, {26'h0, exp});
    end else begin
      // Deferred update lands on a later vsync; two frames is ample
      repeat (500) @(posedge clk_sys);
      check("phase vs", {26'h0, sample_phase}, {26'h0, exp});
    end
    rd_chk(`APAM_IDX_STATUS, 32'h00, "idle");
  endtask : search

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    int n0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    // Reset values and map
    rd_chk(`APAM_IDX_VMASK, 32'h01, "vmask");
    rd_chk(`APAM_IDX_HM_AFTER, 32'h01, "hm after");
    rd_chk(`APAM_IDX_HM_BEFORE, 32'h01, "hm before");
    rd_chk(`APAM_IDX_OPTIONS, 32'h20, "options");
    rd_chk(`APAM_IDX_THRESH, 32'h0A, "thresh");
    rd_chk(`APAM_IDX_STATUS, 32'h00, "status");
    rd_chk(8'h5B, 32'h00, "unmapped");
    // Only the two mask fields are writable
    bus(1'b1, `APAM_IDX_VMASK, 8'hFF);
    rd_chk(`APAM_IDX_VMASK, 32'h77, "vmask fields");
    bus(1'b1, `APAM_IDX_VMASK, 8'h01);
    // A write without its low byte lane is dropped
    avs_byteenable <= 4'hE;
    bus(1'b1, `APAM_IDX_THRESH, 8'h55);
    avs_byteenable <= 4'hF;
    rd_chk(`APAM_IDX_THRESH, 32'h0A, "thresh lane");
    // Every command code except the search
    for (int c = 0; c < 8; c++) begin
      if (c != 3) begin
        n0 = de_cnt;
        bus(1'b1, `APAM_IDX_CMD, c[7:0]);
        repeat (2) @(posedge clk_sys);
        check("de pulses", de_cnt - n0, (c == 4) ? 1 : 0);
        check("no search", {31'h0, phase_operation_active}, 32'h0);
      end
    end
    // Slow best search, immediate update
    search(8'h10, 6'h25, 8'hFF, 8'h00, 3'h7, 6'h25);
    // Fast worst search, deferred; small swing sits under four times 0x0A
    search(8'h28, 6'h16, 8'h20, 8'hFF, 3'h7, 6'h16);
    // Soft reset stops a running search
    bus(1'b1, `APAM_IDX_OPTIONS, 8'h00);
    bus(1'b1, `APAM_IDX_CMD, 8'h03);
    bus(1'b1, `APAM_IDX_OPTIONS, 8'h40);
    repeat (3) @(posedge clk_sys);
    check("soft rst", {31'h0, phase_operation_active}, 32'h0);
    rd_chk(`APAM_IDX_STATUS, 32'h00, "soft rst status");
    bus(1'b1, `APAM_IDX_OPTIONS, 8'h00);
    // All colours toggle and all are off: no counts, earliest phase wins
    search(8'h07, 6'h16, 8'hFF, 8'h00, 3'h7, 6'h00);
    summarize();
  end

  // Watchdog, well beyond the roughly 30000 cycles the tests need
  initial begin
    repeat (90000) @(posedge clk_sys);
    fails++;
    summarize();
  end
endmodule : test_apam_top

`default_nettype wire
